// file: rtl/ssbm_channel.sv
// master channel: host serial port, bus framer, crc and queues
//
// Notes on behaviour
// [R1] crc bits appended to every sent word
// [R2] received crc recomputed; mismatch sets error flag
// [R3] crc error travels with its data read
// [R4] received crc bits stripped before storing
// [R5] serial and bus domains cross safely
// [R6] idle on reset/deselect; write cleared, count 7
// [R7] first command bit is the write flag
// [R8] last five command bits load pointer
// [R9] burst continues until deselect or reset
// [R10] config register writes, except word length, abort bus transfer
// [R11] data low write pushes transmit queue
// [R12] data low access pops nonempty receive queue
// [R13] receive push precedes transmit pop
// [R14] bus machine on third-bit enable; forced gap
// [R15] frame low, one bit delay before data
// [R16] bit index loaded with total length
// [R17] bit phases: low, data, high
// [R18] after crc: store, then release, then gap
// [R19] gap counter restarts at last crc bit
// [R20] transmit queue holds four entries
// [R21] writes ignored while transmit queue full
// [R22] reset/abort/disable empties transmit queue
// [R23] receive queue four deep, oldest first
`timescale 1ns/1ps
module ssbm_channel
   import ssbm_pkg::*;
#(
   parameter int DEPTH = ssbm_pkg::SSBM_FIFO_DEPTH,
   parameter int DIV   = ssbm_pkg::SSBM_THIRD_DIV
) (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic spi_sclk,
   input  wire logic spi_cs_n,
   input  wire logic spi_mosi,
   output logic      spi_miso,
   input  wire logic bus_response,
   output logic      bus_signal_line,
   output logic      bus_frame_n,
   output logic      bus_enable,
   output logic      tx_queue_not_full,
   output logic      rx_queue_not_empty,
   output logic      crc_error
);
   import ssbm_pkg::*;

   // ****************************************
   // serial port sampling
   // ****************************************
   // sclk sampled as a level; rising edge found from the live level against the registered copy
   logic       sclk_d_r;
   logic       sclk_rise;
   logic       deselect;
   always_ff @(posedge clk_sys)
   begin
      sclk_d_r <= rst ? 1'b0 : spi_sclk;
   end
   assign sclk_rise = spi_sclk && !sclk_d_r && !spi_cs_n;
   assign deselect  = spi_cs_n;

   // ****************************************
   // serial state machine
   // ****************************************
   ssbm_spi_t  spi_st_r;
   logic [2:0] bitcnt_r;
   logic       write_r;
   logic [4:0] ptr_r;
   logic [6:0] shin_r;
   logic [7:0] shout_r;
   logic [7:0] rx_byte;
   logic       byte_done;
   assign rx_byte   = {shin_r, spi_mosi};
   assign byte_done = sclk_rise && (bitcnt_r == 3'h0);

   // [R6] idle on reset or deselect
   always_ff @(posedge clk_sys)
   begin
      if (rst || deselect)
      begin
         spi_st_r <= SSBM_SPI_IDLE;
         write_r  <= 1'b0;
         bitcnt_r <= SSBM_BIT_START;
      end
      else if (sclk_rise)
      begin
         bitcnt_r <= bitcnt_r - 3'h1;
         case (spi_st_r)
            // [R7] latch write flag
            SSBM_SPI_IDLE:
            begin
               write_r  <= spi_mosi;
               spi_st_r <= host_command_state;
            end
            host_command_state:
            begin
               if (bitcnt_r == 3'h0)
               begin
                  spi_st_r <= SSBM_SPI_BURST;
               end
            end
            // [R9] stay in burst
            SSBM_SPI_BURST: spi_st_r <= SSBM_SPI_BURST;
            default: spi_st_r <= SSBM_SPI_IDLE;
         endcase
      end
   end

   // shift-in register, msb first
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         shin_r <= 7'h00;
      end
      else if (sclk_rise)
      begin
         shin_r <= rx_byte[6:0];
      end
   end

   // [R8] pointer load from command, then step per burst byte
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         ptr_r <= 5'h00;
      end
      else if (byte_done && spi_st_r == host_command_state)
      begin
         ptr_r <= rx_byte[SSBM_PTR_W-1:0];
      end
      else if (byte_done && spi_st_r == SSBM_SPI_BURST)
      begin
         ptr_r <= ptr_r + 5'h01;
      end
   end

   // ****************************************
   // registers and host side strobes
   // ****************************************
   logic        wr_strobe;
   logic        acc_lo;
   logic        abort;
   logic        enable_r;
   logic        long_word_select;
   logic [3:0]  short_word_length;
   logic [3:0]  check_length;
   logic [7:0]  check_polynomial;
   logic [7:0]  check_initial_value;
   logic [7:0]  spread_r;
   logic [7:0]  data_hi_r;
   logic        tx_push;
   logic        rx_pop;
   logic        tx_full;
   logic        tx_empty;
   logic        rx_empty;
   logic [16:0] rx_head;
   assign wr_strobe = byte_done && spi_st_r == SSBM_SPI_BURST && write_r;
   assign acc_lo    = byte_done && spi_st_r == SSBM_SPI_BURST && ptr_r == SSBM_REG_DATA_LO;

   // [R10] config writes abort, except the word length register
   assign abort = wr_strobe && (ptr_r == SSBM_REG_CTRL || ptr_r == SSBM_REG_POLY
                  || ptr_r == SSBM_REG_SEED || ptr_r == SSBM_REG_CRCLEN
                  || ptr_r == SSBM_REG_SPREAD);
   // [R11] [R21] push only when room
   assign tx_push = wr_strobe && ptr_r == SSBM_REG_DATA_LO && !tx_full;
   // [R12] pop on low-byte access
   assign rx_pop  = acc_lo && !rx_empty;

   // configuration registers
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         enable_r            <= 1'b0;
         long_word_select    <= 1'b0;
         short_word_length   <= SSBM_SWLEN_RST;
         check_length        <= SSBM_CRCLEN_RST;
         check_polynomial    <= SSBM_POLY_RST;
         check_initial_value <= SSBM_SEED_RST;
         spread_r            <= 8'h00;
         data_hi_r           <= 8'h00;
      end
      else if (wr_strobe)
      begin
         case (ptr_r)
            SSBM_REG_CTRL:   {long_word_select, enable_r} <= {rx_byte[1], rx_byte[0]};
            SSBM_REG_POLY:   check_polynomial    <= rx_byte;
            SSBM_REG_SEED:   check_initial_value <= rx_byte;
            SSBM_REG_CRCLEN: check_length        <= rx_byte[3:0];
            SSBM_REG_SPREAD: spread_r            <= rx_byte;
            SSBM_REG_DATA_HI: data_hi_r          <= rx_byte;
            SSBM_REG_WLEN:   short_word_length   <= rx_byte[3:0];
            default:         spread_r            <= spread_r;
         endcase
      end
   end

   // read mux; [R3] crc flag of the head entry read with its data
   logic [7:0] rd_val;
   logic [4:0] rd_ptr;
   // pointer register is still stale at command end, so use the fresh field
   assign rd_ptr = (spi_st_r == host_command_state) ? rx_byte[SSBM_PTR_W-1:0]
                                                    : ptr_r + 5'h01;
   always_comb
   begin
      rd_val = 8'h00;
      case (rd_ptr)
         SSBM_REG_CTRL:    rd_val = {6'h00, long_word_select, enable_r};
         SSBM_REG_POLY:    rd_val = check_polynomial;
         SSBM_REG_SEED:    rd_val = check_initial_value;
         SSBM_REG_CRCLEN:  rd_val = {4'h0, check_length};
         SSBM_REG_SPREAD:  rd_val = spread_r;
         SSBM_REG_DATA_HI: rd_val = rx_head[15:8];
         SSBM_REG_DATA_LO: rd_val = rx_head[7:0];
         SSBM_REG_STATUS:  rd_val = {4'h0, rx_head[16] && !rx_empty, !rx_empty,
                                     tx_empty, !tx_full};
         SSBM_REG_WLEN:    rd_val = {4'h0, short_word_length};
         default:          rd_val = 8'h00;
      endcase
   end

   // output shifter, loads next register at each byte end
   always_ff @(posedge clk_sys)
   begin
      if (rst || deselect)
      begin
         shout_r <= 8'h00;
      end
      else if (byte_done)
      begin
         shout_r <= rd_val;
      end
      else if (sclk_rise)
      begin
         shout_r <= {shout_r[6:0], 1'b0};
      end
   end
   assign spi_miso = shout_r[7];

   // ****************************************
   // queues
   // ****************************************
   // [R5] both sides run on one clock here and meet through the queues and the config registers
   logic        bus_clear;
   logic        rx_push;
   logic        tx_pop;
   logic [15:0] tx_head;
   logic [16:0] rx_word;
   assign bus_clear = rst || abort || !enable_r;

   // [R20] [R22] four deep transmit queue, cleared on reset/abort/disable
   ssbm_fifo #(.WIDTH(16), .DEPTH(DEPTH)) u_txq (
      .clk_sys   (clk_sys),
      .clear     (bus_clear),
      .push      (tx_push),
      .push_data ({data_hi_r, rx_byte}),
      .pop       (tx_pop),
      .head_data (tx_head),
      .empty     (tx_empty),
      .full      (tx_full)
   );

   // [R23] receive queue, oldest first
   ssbm_fifo #(.WIDTH(17), .DEPTH(DEPTH)) u_rxq (
      .clk_sys   (clk_sys),
      .clear     (rst),
      .push      (rx_push),
      .push_data (rx_word),
      .pop       (rx_pop),
      .head_data (rx_head),
      .empty     (rx_empty),
      .full      ()
   );

   // ****************************************
   // bus framer
   // ****************************************
   // third-bit enable from a divider; limitation: no spreading of the rate
   logic [7:0]  div_r;
   logic        third_en;
   always_ff @(posedge clk_sys)
   begin
      if (rst || div_r == 8'(DIV-1))
      begin
         div_r <= 8'h00;
      end
      else
      begin
         div_r <= div_r + 8'h01;
      end
   end
   assign third_en = (div_r == 8'(DIV-1));

   ssbm_bus_t   bus_st_r;
   logic [1:0]  phase_r;
   logic [4:0]  bit_index_counter;
   logic [4:0]  data_len;
   logic [4:0]  total_len;
   logic [3:0]  gap_r;
   logic [7:0]  crc_tx_r;
   logic [7:0]  crc_rx_r;
   logic [15:0] rx_data_r;
   logic [7:0]  rx_crc_r;
   logic        tx_bit;
   logic        last_bit;
   logic        in_crc;
   logic [7:0]  crc_mask;
   assign data_len  = long_word_select ? SSBM_LONG_LEN : {1'b0, short_word_length};
   assign total_len = data_len + {1'b0, check_length};
   assign in_crc    = bit_index_counter <= {1'b0, check_length};
   assign last_bit  = third_en && bus_st_r == bit_phase_state && phase_r == 2'h2
                      && bit_index_counter == 5'h01;
   assign crc_mask  = 8'((9'h001 << check_length) - 9'h001);
   // [R1] data bits msb first, then crc bits msb first
   assign tx_bit = in_crc ? crc_tx_r[3'(bit_index_counter - 5'h01)]
                          : tx_head[4'(bit_index_counter - {1'b0, check_length} - 5'h01)];

   // crc step for one serial bit over a programmable polynomial
   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b,
                                           input logic [7:0] poly, input logic [3:0] len);
      logic fb;
      fb = c[3'(len - 4'h1)] ^ b;
      crc_step = ((c << 1) ^ (fb ? poly : 8'h00)) & (8'((9'h001 << len) - 9'h001));
   endfunction

   // [R14] forced to gap state by clear; stepping on the third enable
   always_ff @(posedge clk_sys)
   begin
      if (bus_clear)
      begin
         bus_st_r          <= frame_gap_state;
         phase_r           <= 2'h0;
         bit_index_counter <= 5'h00;
      end
      else if (third_en)
      begin
         case (bus_st_r)
            // [R15] start frame once gap elapsed and data waiting
            frame_gap_state:
            begin
               phase_r <= 2'h0;
               if (!tx_empty && gap_r == 4'h0)
               begin
                  bus_st_r <= lead_delay_state;
               end
            end
            lead_delay_state:
            begin
               phase_r <= phase_r + 2'h1;
               if (phase_r == 2'h2)
               begin
                  phase_r           <= 2'h0;
                  // [R16] load total word length
                  bit_index_counter <= total_len;
                  bus_st_r          <= bit_phase_state;
               end
            end
            bit_phase_state:
            begin
               phase_r <= phase_r + 2'h1;
               if (phase_r == 2'h2)
               begin
                  phase_r           <= 2'h0;
                  bit_index_counter <= bit_index_counter - 5'h01;
                  if (bit_index_counter == 5'h01)
                  begin
                     bus_st_r <= rx_store_state;
                  end
               end
            end
            // [R18] [R13] store then release, then gap
            rx_store_state:   bus_st_r <= tx_release_state;
            tx_release_state: bus_st_r <= frame_gap_state;
            default:          bus_st_r <= frame_gap_state;
         endcase
      end
   end
   assign rx_push = third_en && bus_st_r == rx_store_state;
   assign tx_pop  = third_en && bus_st_r == tx_release_state;

   // [R19] gap counter restarts at the end of the last crc bit
   always_ff @(posedge clk_sys)
   begin
      if (rst || last_bit)
      begin
         gap_r <= 4'(SSBM_GAP_THIRDS);
      end
      else if (third_en && gap_r != 4'h0)
      begin
         gap_r <= gap_r - 4'h1;
      end
   end

   // [R17] low, data, high thirds; frame low from lead delay to last bit
   always_ff @(posedge clk_sys)
   begin
      if (bus_clear)
      begin
         bus_signal_line <= 1'b1;
         bus_frame_n     <= 1'b1;
      end
      else
      begin
         bus_frame_n <= !(bus_st_r == lead_delay_state || bus_st_r == bit_phase_state);
         if (bus_st_r == bit_phase_state)
         begin
            bus_signal_line <= (phase_r == 2'h2) || (phase_r == 2'h1 && tx_bit);
         end
         else
         begin
            bus_signal_line <= 1'b1;
         end
      end
   end

   // [R1] [R2] crc over sent data and over received data
   always_ff @(posedge clk_sys)
   begin
      if (bus_clear || (third_en && bus_st_r == lead_delay_state))
      begin
         crc_tx_r  <= check_initial_value & crc_mask;
         crc_rx_r  <= check_initial_value & crc_mask;
         rx_data_r <= 16'h0000;
         rx_crc_r  <= 8'h00;
      end
      else if (third_en && bus_st_r == bit_phase_state && phase_r == 2'h1)
      begin
         if (!in_crc)
         begin
            crc_tx_r  <= crc_step(crc_tx_r, tx_bit, check_polynomial, check_length);
            crc_rx_r  <= crc_step(crc_rx_r, bus_response, check_polynomial, check_length);
            // [R4] only data bits enter the data shift register
            rx_data_r <= {rx_data_r[14:0], bus_response};
         end
         else
         begin
            rx_crc_r <= {rx_crc_r[6:0], bus_response};
         end
      end
   end
   // [R2] mismatch flag stored beside the data
   assign rx_word = {rx_crc_r != crc_rx_r, rx_data_r};

   // ****************************************
   // status outputs
   // ****************************************
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         bus_enable         <= 1'b0;
         tx_queue_not_full  <= 1'b1;
         rx_queue_not_empty <= 1'b0;
         crc_error          <= 1'b0;
      end
      else
      begin
         bus_enable         <= enable_r;
         tx_queue_not_full  <= !tx_full;
         rx_queue_not_empty <= !rx_empty;
         crc_error          <= rx_head[16] && !rx_empty;
      end
   end
endmodule

// file: rtl/ssbm_pkg.sv
// package of constants and types for the sensor bus master channel
package ssbm_pkg;
   // ****************************************
   // command and register pointer layout
   // ****************************************
   localparam int          SSBM_PTR_W        = 5;
   localparam logic [2:0]  SSBM_BIT_START    = 3'h7;
   localparam int          SSBM_CMD_RW_BIT   = 7;
   localparam logic [4:0]  SSBM_REG_CTRL     = 5'h00;
   localparam logic [4:0]  SSBM_REG_POLY     = 5'h01;
   localparam logic [4:0]  SSBM_REG_SEED     = 5'h02;
   localparam logic [4:0]  SSBM_REG_CRCLEN   = 5'h03;
   localparam logic [4:0]  SSBM_REG_SPREAD   = 5'h04;
   localparam logic [4:0]  SSBM_REG_DATA_HI  = 5'h05;
   localparam logic [4:0]  SSBM_REG_DATA_LO  = 5'h06;
   localparam logic [4:0]  SSBM_REG_STATUS   = 5'h07;
   localparam logic [4:0]  SSBM_REG_WLEN     = 5'h08;
   // ****************************************
   // reset values and timing
   // ****************************************
   localparam logic [7:0]  SSBM_POLY_RST     = 8'h01;
   localparam logic [7:0]  SSBM_SEED_RST     = 8'h0A;
   localparam logic [3:0]  SSBM_CRCLEN_RST   = 4'h4;
   localparam logic [3:0]  SSBM_SWLEN_RST    = 4'h8;
   localparam logic [4:0]  SSBM_LONG_LEN     = 5'h10;
   localparam int          SSBM_THIRD_DIV    = 4;
   localparam int          SSBM_GAP_THIRDS   = 6;
   localparam int          SSBM_FIFO_DEPTH   = 4;
   // status bit positions
   localparam int          SSBM_ST_TXNF      = 0;
   localparam int          SSBM_ST_TXEMPTY   = 1;
   localparam int          SSBM_ST_RXNE      = 2;
   localparam int          SSBM_ST_CRCERR    = 3;
   // ****************************************
   // state encodings
   // ****************************************
   typedef enum logic [2:0] {
      SSBM_SPI_IDLE      = 3'b001,
      host_command_state = 3'b010,
      SSBM_SPI_BURST     = 3'b100
   } ssbm_spi_t;
   typedef enum logic [5:0] {
      frame_gap_state  = 6'b000001,
      lead_delay_state = 6'b000010,
      bit_phase_state  = 6'b000100,
      rx_store_state   = 6'b001000,
      tx_release_state = 6'b010000,
      SSBM_BUS_SPARE   = 6'b100000
   } ssbm_bus_t;
endpackage

// file: rtl/ssbm_fifo.sv
// small first-in first-out store used for the transmit and receive queues
`timescale 1ns/1ps
module ssbm_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input  wire logic             clk_sys,
   input  wire logic             clear,
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] push_data,
   input  wire logic             pop,
   output logic      [WIDTH-1:0] head_data,
   output logic                  empty,
   output logic                  full
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_r;
   logic [AW-1:0]    rd_r;
   logic [AW:0]      cnt_r;
   logic             do_push;
   logic             do_pop;

   // pushes into a full queue are dropped, pops of an empty one too
   assign do_push   = push && !full;
   assign do_pop    = pop && !empty;
   assign empty     = (cnt_r == '0);
   assign full      = (cnt_r == (AW+1)'(DEPTH));
   assign head_data = mem_r[rd_r];

   // storage array
   always_ff @(posedge clk_sys)
   begin
      if (do_push)
      begin
         mem_r[wr_r] <= push_data;
      end
   end

   // pointers and fill count, clear wins
   always_ff @(posedge clk_sys)
   begin
      if (clear)
      begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (do_push)
         begin
            wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
         end
         if (do_pop)
         begin
            rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end
endmodule

// file: tb/ssbm_channel_props.sv
// port-level assertions for the sensor bus master channel
`timescale 1ns/1ps
module ssbm_chk (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic spi_cs_n,
   input wire logic bus_signal_line,
   input wire logic bus_frame_n,
   input wire logic bus_enable,
   input wire logic tx_queue_not_full,
   input wire logic rx_queue_not_empty,
   input wire logic crc_error
);
   // ****************************************
   // checks, all on the system clock
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   chk_reset_idle_lines: assert property ($fell(rst) |-> bus_frame_n && bus_signal_line
      && !bus_enable && tx_queue_not_full) else $error("lines not idle after reset");
   chk_bit_low_third: assert property ($fell(bus_signal_line) |-> (!bus_signal_line)[*8])
      else $error("bit low phase too short");
   chk_bit_high_third: assert property ($rose(bus_signal_line) |-> bus_signal_line[*8])
      else $error("bit high phase too short");
   chk_idle_line_high: assert property (bus_frame_n |-> bus_signal_line)
      else $error("signal low outside a frame");
   chk_frame_lead: assert property ($fell(bus_frame_n) |-> bus_enable ##0 bus_signal_line[*8])
      else $error("frame start without lead delay");
   chk_frame_gap: assert property ($rose(bus_frame_n) |-> bus_frame_n[*8] ##1 bus_frame_n[*8])
      else $error("frames too close");
   chk_disable_idle: assert property ((!bus_enable)[*2] |-> bus_frame_n && tx_queue_not_full)
      else $error("disabled channel not idle");
   chk_crc_paired: assert property ($changed(crc_error) |-> $changed(rx_queue_not_empty)
      || !spi_cs_n || !$past(spi_cs_n)) else $error("crc flag moved without its data");
   chk_rx_pop_host: assert property ($fell(rx_queue_not_empty) |-> !spi_cs_n || !$past(spi_cs_n))
      else $error("receive queue drained without access");
   chk_tx_push_host: assert property ($fell(tx_queue_not_full) |-> !spi_cs_n || !$past(spi_cs_n))
      else $error("transmit queue filled without write");
   cov_frame: cover property ($fell(bus_frame_n));
   cov_crc: cover property ($rose(crc_error));
   cov_full: cover property ($fell(tx_queue_not_full));
endmodule
bind ssbm_channel ssbm_chk ssbm_chk_inst (.clk_sys, .rst, .spi_cs_n, .bus_signal_line,
   .bus_frame_n, .bus_enable, .tx_queue_not_full, .rx_queue_not_empty, .crc_error);

// file: tb/ssbm_node_model.sv
// remote node model: answers each frame and records the bits it saw
`timescale 1ns/1ps
module ssbm_node_model #(
   parameter int DIV = 16
) (
   input  wire logic        clk_sys,
   input  wire logic        bus_signal_line,
   input  wire logic        bus_frame_n,
   input  wire logic [11:0] resp_word,
   output logic             bus_response,
   output logic [11:0]      sent_word,
   output int               bits_seen,
   output int               frames
);
   int          cnt = 0;
   int          idx = 0;
   logic [11:0] shift = 12'h000;
   logic        sig_q = 1'b1;
   logic        frm_q = 1'b1;
   logic [11:0] rw;
   initial
   begin
      bus_response = 1'b0;
      sent_word    = 12'h000;
      bits_seen    = 0;
      frames       = 0;
   end
   // answer data moves with the frame count so queue order shows
   assign rw = {resp_word[11:4] + frames[7:0], resp_word[3:0]};
   // answer on each bit start, sample the middle third
   always @(posedge clk_sys)
   begin
      sig_q <= bus_signal_line;
      frm_q <= bus_frame_n;
      cnt   <= cnt + 1;
      if (bus_frame_n)
         bus_response <= !bus_response;  // released: no level worth trusting
      if (!bus_frame_n && sig_q && !bus_signal_line)
      begin
         cnt          <= 1;
         idx          <= idx + 1;
         bus_response <= (idx < 12) ? rw[11 - idx] : !bus_response;
      end
      if (!bus_frame_n && cnt == DIV + DIV / 2)
         shift <= {shift[10:0], bus_signal_line};
      if (bus_frame_n && !frm_q)
      begin
         sent_word <= shift;
         bits_seen <= idx;
         frames    <= frames + 1;
         idx       <= 0;
      end
   end
endmodule

// file: tb/test_serial_sensor_bus_master_channel.sv
// self-checking bench for the sensor bus master channel
`timescale 1ns/1ps
module test_serial_sensor_bus_master_channel;
   import ssbm_pkg::*;
   localparam int DV = 16;  // slow thirds so four words queue up before one leaves
   logic        clk_sys = 0, rst = 1, spi_sclk = 0, spi_cs_n = 1, spi_mosi = 0;
   logic [11:0] resp_word = 12'h00A;
   logic [7:0]  rd;
   wire logic   spi_miso, bus_response, bus_signal_line, bus_frame_n, bus_enable;
   wire logic   tx_queue_not_full, rx_queue_not_empty, crc_error;
   wire logic [11:0] sent_word;
   int          bits_seen, frames, failures = 0, compares = 0, cyc = 0;
   ssbm_channel #(.DIV(DV)) ssbm_channel_inst (.clk_sys, .rst, .spi_sclk, .spi_cs_n,
      .spi_mosi, .spi_miso, .bus_response, .bus_signal_line, .bus_frame_n, .bus_enable,
      .tx_queue_not_full, .rx_queue_not_empty, .crc_error);
   ssbm_node_model #(.DIV(DV)) ssbm_node_model_inst (.clk_sys, .bus_signal_line,
      .bus_frame_n, .resp_word, .bus_response, .sent_word, .bits_seen, .frames);
   // ****************************************
   // clock, watchdog and shared tasks
   // ****************************************
   initial
      forever #20 clk_sys = ~clk_sys;
   // a hang counts as a mismatch
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         failures++;
         complete_run();
      end
   end
   task tk(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task cmp_val(input logic [11:0] got, input logic [11:0] exp);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task cmp_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   // miso is looked at just before the rise that shifts it
   task spi_byte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         spi_mosi = tx[i];
         tk(2);
         rx[i] = spi_miso;
         spi_sclk = 1;
         tk(2);
         spi_sclk = 0;
      end
   endtask
   task xfer(input logic wr, input logic [4:0] ptr, input logic [7:0] val);
      logic [7:0] junk;
      spi_cs_n = 0;
      tk(2);
      spi_byte({wr, 2'b00, ptr}, junk);
      spi_byte(val, rd);
      tk(2);
      spi_cs_n = 1;
      tk(4);
   endtask
   task rdc(input logic [4:0] ptr, input logic [7:0] exp, input logic [7:0] m);
      xfer(1'b0, ptr, 8'h00);
      cmp_val({4'h0, rd & m}, {4'h0, exp});
   endtask
   task wait_frames(input int n);
      int f0;
      f0 = frames + n;
      for (int k = 0; k < 4000 * n && frames < f0; k++)
         tk(1);
      cmp_val(frames[11:0], f0[11:0]);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task t_reset;
      rdc(SSBM_REG_POLY, SSBM_POLY_RST, 8'hFF);
      rdc(SSBM_REG_SEED, SSBM_SEED_RST, 8'hFF);
      rdc(SSBM_REG_CRCLEN, {4'h0, SSBM_CRCLEN_RST}, 8'h0F);
      rdc(SSBM_REG_WLEN, {4'h0, SSBM_SWLEN_RST}, 8'h0F);
      rdc(SSBM_REG_STATUS, 8'h03, 8'h0F);
      wr_ctrl_on();
   endtask
   task wr_ctrl_on;
      xfer(1'b1, SSBM_REG_CTRL, 8'h01);
   endtask
   // zero data answers with a known check pattern; any other is a mismatch
   task t_crc(input logic [3:0] c, input logic err);
      resp_word = {8'h00 - frames[7:0], c};
      xfer(1'b1, SSBM_REG_DATA_LO, 8'h00);
      wait_frames(1);
      cmp_val(sent_word, 12'h00A);
      cmp_val(bits_seen[11:0], 12'h00C);
      tk(4 * DV);
      rdc(SSBM_REG_STATUS, {4'h0, err, 3'b111}, 8'h0F);
      cmp_bit(crc_error, err);
      rdc(SSBM_REG_DATA_LO, 8'h00, 8'hFF);
      cmp_bit(rx_queue_not_empty, 1'b0);
   endtask
   task t_fill;
      int f0;
      f0 = frames;
      resp_word = 12'h30A;
      for (int i = 1; i <= 4; i++)
         xfer(1'b1, SSBM_REG_DATA_LO, 8'h11 * i);
      cmp_bit(tx_queue_not_full, 1'b0);
      xfer(1'b1, SSBM_REG_DATA_LO, 8'h99);
      wait_frames(4);
      cmp_val({4'h0, sent_word[11:4]}, 12'h044);
      tk(60 * DV);
      cmp_val(frames[11:0], f0[11:0] + 12'h004);
      for (int k = 0; k < 4; k++)
         rdc(SSBM_REG_DATA_LO, 8'h30 + f0[7:0] + k[7:0], 8'hFF);
   endtask
   task t_abort;
      logic [4:0] regs [5];
      logic [7:0] vals [5];
      regs = '{SSBM_REG_POLY, SSBM_REG_SEED, SSBM_REG_CRCLEN, SSBM_REG_CTRL, SSBM_REG_SPREAD};
      vals = '{SSBM_POLY_RST, SSBM_SEED_RST, 8'h04, 8'h01, 8'h00};
      for (int i = 0; i < 5; i++)
      begin
         xfer(1'b1, SSBM_REG_DATA_LO, 8'h5A);
         for (int k = 0; k < 4000 && bus_frame_n; k++)
            tk(1);
         cmp_bit(bus_frame_n, 1'b0);
         xfer(1'b1, regs[i], vals[i]);
         cmp_bit(bus_frame_n, 1'b1);
         rdc(SSBM_REG_STATUS, 8'h03, 8'h0F);
      end
      xfer(1'b1, SSBM_REG_CTRL, 8'h00);
      cmp_bit(bus_enable, 1'b0);
   endtask
   task complete_run;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      tk(20);
      rst = 0;
      tk(2);
      t_reset();
      t_crc(4'hA, 1'b0);
      t_crc(4'h5, 1'b1);
      t_fill();
      t_abort();
      complete_run();
   end
endmodule
